// file: design/ppid_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the process regulator
// Assumes: 100 MHz hclk, word-aligned AHB-Lite register map
// Notes:   all settings use fixed-point units noted beside each value
`ifndef PPID_CFG_SVH
`define PPID_CFG_SVH
// register byte offsets
`define PPID_OFS_SRC      8'h00
`define PPID_OFS_FSEL     8'h04
`define PPID_OFS_KEYPAD   8'h08
`define PPID_OFS_KP       8'h0C
`define PPID_OFS_TI       8'h10
`define PPID_OFS_TD       8'h14
`define PPID_OFS_TS       8'h18
`define PPID_OFS_DBAND    8'h1C
`define PPID_OFS_FMAX     8'h20
`define PPID_OFS_STATUS   8'h24
`define PPID_OFS_FCMD     8'h28
// field positions inside the source register
`define PPID_SP_LSB       0
`define PPID_FB_LSB       8
`define PPID_POL_BIT      16
// selector limits and the code that makes the regulator the frequency source
`define PPID_SP_MAX       4'h8
`define PPID_FB_MAX       4'h9
`define PPID_FSEL_PID     4'h6
// reset values (percent in 0.1 %, gain in 0.01, times in 0.01 s, frequency in 0.01 Hz)
`define PPID_RST_KEYPAD   16'h0000
`define PPID_RST_KP       16'h000A
`define PPID_RST_TI       16'h000A
`define PPID_RST_TD       16'h0000
`define PPID_RST_TS       16'h0032
`define PPID_RST_DBAND    16'h0000
`define PPID_RST_FMAX     16'h1388
// setting limits
`define PPID_FULL         1000
`define PPID_KP_MAX       10000
`define PPID_TI_MAX       1000
`define PPID_TD_MAX       1000
`define PPID_TS_MAX       10000
// timing: one time unit of the period setting is 10 ms
`define PPID_CLK_NS       10
`define PPID_UNIT_NS      10000000
`define PPID_UNIT_CYCLES  (`PPID_UNIT_NS / `PPID_CLK_NS)
`endif

// file: design/ppid_pkg.sv
// Purpose: shared types of the process regulator
// Assumes: constants live in ppid_cfg.svh
// Notes:   selector encodings follow the register fields
package ppid_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [3:0] {
        PPID_SP_KEYPAD = 4'h0, PPID_SP_AN1 = 4'h1, PPID_SP_AN2 = 4'h2,
        PPID_SP_AN3    = 4'h3, PPID_SP_AN4 = 4'h4, PPID_SP_PL1 = 4'h5,
        PPID_SP_PL2    = 4'h6, PPID_SP_REM = 4'h7, PPID_SP_MULTI = 4'h8
    } ppid_sp_src_t;
    typedef enum logic [3:0] {
        PPID_FB_AN1   = 4'h0, PPID_FB_AN2 = 4'h1, PPID_FB_AN3 = 4'h2,
        PPID_FB_AN4   = 4'h3, PPID_FB_D12 = 4'h4, PPID_FB_D34 = 4'h5,
        PPID_FB_PL1   = 4'h6, PPID_FB_PL2 = 4'h7, PPID_FB_DPL = 4'h8,
        PPID_FB_REM   = 4'h9
    } ppid_fb_src_t;
    typedef enum logic {PPID_POL_POS = 1'b0, PPID_POL_NEG = 1'b1} ppid_pol_t;
endpackage : ppid_pkg

// file: design/ppid_regulator.sv
// Purpose: process PID regulator trimming the drive frequency command, AHB-Lite registers
// Assumes: all inputs synchronous to hclk; process values signed, 0.1 % units
// Notes:   reads take one wait state, writes none; response always OKAY
//
// Notes on behaviour
// - setpoint source codes 0..8: keypad, analog 1-4, pulse 1-2, remote, multistage.
// - feedback source codes 0..9 including analog and pulse differences and remote.
// - regulator works only while frequency source selector holds the PID code.
// - setpoint and feedback are relative, full scale equals full scale.
// - keypad preset ranges minus to plus full scale in 0.1 %, default zero.
// - positive polarity lowers frequency when feedback exceeds setpoint; default.
// - negative polarity raises frequency when feedback exceeds setpoint.
// - gain 0.00..100.00, default 0.10; gain 100 at full error gives maximum frequency.
// - integral time 0.01..10.00 s; full error reaches maximum after that time.
// - derivative time 0.00..10.00 s; full feedback change in that time gives maximum.
// - proportional term is a fixed multiple of the present error.
// - integral accumulates only while error exceeds the deadband, limited to full scale.
// - one update per sampling period, 0.01..100.00 s, default 0.50 s.
// - output held while absolute error lies within the deadband limit.
`include "ppid_cfg.svh"

module ppid_regulator #(
    parameter int unsigned UNIT_CYCLES = `PPID_UNIT_CYCLES
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic signed [15:0] analog_channel_one,
    input  wire logic signed [15:0] analog_channel_two,
    input  wire logic signed [15:0] analog_channel_three,
    input  wire logic signed [15:0] analog_channel_four,
    input  wire logic signed [15:0] pulse_input_one,
    input  wire logic signed [15:0] pulse_input_two,
    input  wire logic signed [15:0] remote_setpoint,
    input  wire logic signed [15:0] remote_feedback,
    input  wire logic signed [15:0] multistage_setpoint,
    output logic [15:0]             freq_command,
    output logic                    pid_active
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // bus front end

    logic                         wr_pend_q;
    logic [7:0]                   wr_addr_q;
    logic                         rd_wait_q;
    logic [7:0]                   rd_addr_q;
    logic [31:0]                  rdata_q;
    logic                         take;

    ppid_pkg::ppid_sp_src_t       sp_sel_q;
    ppid_pkg::ppid_fb_src_t       fb_sel_q;
    ppid_pkg::ppid_pol_t          pol_q;
    logic [3:0]                   fsel_q;
    logic signed [15:0]           keypad_q;
    logic [15:0]                  kp_q, ti_q, td_q, ts_q, dband_q, fmax_q;
    logic [15:0]                  fcmd_q;
    logic signed [31:0]           acc_q;
    logic signed [15:0]           fb_prev_q;
    logic                         hold_q;

    // only word transfers are meaningful; hsize is ignored and an offset not on a word matches no register
    assign take      = hsel && hready && htrans[1];
    assign hreadyout = !rd_wait_q;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // address phase capture; a read waits one cycle so it sees a write just before
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_wait_q <= 1'b0;
            rd_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_wait_q <= take && !hwrite;
            if (take) begin
                wr_addr_q <= haddr[7:0];
                rd_addr_q <= haddr[7:0];
            end
        end
    end

    // read mux, loaded in the wait cycle; unmapped offsets read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_wait_q) begin
            case (rd_addr_q)
                `PPID_OFS_SRC:    rdata_q <= {15'h0000, pol_q, 4'h0, fb_sel_q, 4'h0, sp_sel_q};
                `PPID_OFS_FSEL:   rdata_q <= {28'h000_0000, fsel_q};
                `PPID_OFS_KEYPAD: rdata_q <= {{16{keypad_q[15]}}, keypad_q};
                `PPID_OFS_KP:     rdata_q <= {16'h0000, kp_q};
                `PPID_OFS_TI:     rdata_q <= {16'h0000, ti_q};
                `PPID_OFS_TD:     rdata_q <= {16'h0000, td_q};
                `PPID_OFS_TS:     rdata_q <= {16'h0000, ts_q};
                `PPID_OFS_DBAND:  rdata_q <= {16'h0000, dband_q};
                `PPID_OFS_FMAX:   rdata_q <= {16'h0000, fmax_q};
                `PPID_OFS_STATUS: rdata_q <= {30'h0000_0000, hold_q, pid_active};
                `PPID_OFS_FCMD:   rdata_q <= {16'h0000, fcmd_q};
                default:          rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings; a write outside a field's range is ignored so divisors never hit zero

    logic signed [15:0] wd16;
    assign wd16 = hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_sel_q <= ppid_pkg::PPID_SP_KEYPAD;
            fb_sel_q <= ppid_pkg::PPID_FB_AN1;
            pol_q    <= ppid_pkg::PPID_POL_POS;
            fsel_q   <= 4'h0;
            keypad_q <= `PPID_RST_KEYPAD;
            kp_q     <= `PPID_RST_KP;
            ti_q     <= `PPID_RST_TI;
            td_q     <= `PPID_RST_TD;
            ts_q     <= `PPID_RST_TS;
            dband_q  <= `PPID_RST_DBAND;
            fmax_q   <= `PPID_RST_FMAX;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `PPID_OFS_SRC: begin
                    if (hwdata[`PPID_SP_LSB +: 4] <= `PPID_SP_MAX)
                        sp_sel_q <= ppid_pkg::ppid_sp_src_t'(hwdata[`PPID_SP_LSB +: 4]);
                    if (hwdata[`PPID_FB_LSB +: 4] <= `PPID_FB_MAX)
                        fb_sel_q <= ppid_pkg::ppid_fb_src_t'(hwdata[`PPID_FB_LSB +: 4]);
                    pol_q <= ppid_pkg::ppid_pol_t'(hwdata[`PPID_POL_BIT]);
                end
                `PPID_OFS_FSEL: fsel_q <= hwdata[3:0];
                `PPID_OFS_KEYPAD: begin
                    if (wd16 >= -16'sd1000 && wd16 <= 16'sd1000)
                        keypad_q <= wd16;
                end
                `PPID_OFS_KP: begin
                    if (hwdata[15:0] <= 16'(`PPID_KP_MAX)) kp_q <= hwdata[15:0];
                end
                `PPID_OFS_TI: begin
                    if (hwdata[15:0] != 16'h0000 && hwdata[15:0] <= 16'(`PPID_TI_MAX))
                        ti_q <= hwdata[15:0];
                end
                `PPID_OFS_TD: begin
                    if (hwdata[15:0] <= 16'(`PPID_TD_MAX)) td_q <= hwdata[15:0];
                end
                `PPID_OFS_TS: begin
                    if (hwdata[15:0] != 16'h0000 && hwdata[15:0] <= 16'(`PPID_TS_MAX))
                        ts_q <= hwdata[15:0];
                end
                `PPID_OFS_DBAND: begin
                    if (hwdata[15:0] <= 16'(`PPID_FULL)) dband_q <= hwdata[15:0];
                end
                `PPID_OFS_FMAX: fmax_q <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sampling period timing

    logic [31:0] unit_cnt_q;
    logic [15:0] per_cnt_q;
    logic        upd;

    // base tick every 10 ms, then count ticks up to the period setting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_cnt_q <= 32'h0000_0000;
            per_cnt_q  <= 16'h0000;
        end else if (unit_cnt_q >= UNIT_CYCLES - 1) begin
            unit_cnt_q <= 32'h0000_0000;
            per_cnt_q  <= (per_cnt_q + 16'h0001 >= ts_q) ? 16'h0000 : per_cnt_q + 16'h0001;
        end else begin
            unit_cnt_q <= unit_cnt_q + 32'h0000_0001;
        end
    end
    assign upd = (unit_cnt_q >= UNIT_CYCLES - 1) && (per_cnt_q + 16'h0001 >= ts_q);

    ////////////////////////////////////////////////////////////////////////////
    // source selection; differences saturate to full scale

    function automatic logic signed [15:0] ppid_sat(input logic signed [16:0] v);
        if (v > 17'sd1000) return 16'sd1000;
        if (v < -17'sd1000) return -16'sd1000;
        return v[15:0];
    endfunction : ppid_sat

    logic signed [15:0] sp_v, fb_v;

    always_comb begin
        case (sp_sel_q)
            ppid_pkg::PPID_SP_KEYPAD: sp_v = keypad_q;
            ppid_pkg::PPID_SP_AN1:    sp_v = ppid_sat(17'(analog_channel_one));
            ppid_pkg::PPID_SP_AN2:    sp_v = ppid_sat(17'(analog_channel_two));
            ppid_pkg::PPID_SP_AN3:    sp_v = ppid_sat(17'(analog_channel_three));
            ppid_pkg::PPID_SP_AN4:    sp_v = ppid_sat(17'(analog_channel_four));
            ppid_pkg::PPID_SP_PL1:    sp_v = ppid_sat(17'(pulse_input_one));
            ppid_pkg::PPID_SP_PL2:    sp_v = ppid_sat(17'(pulse_input_two));
            ppid_pkg::PPID_SP_REM:    sp_v = ppid_sat(17'(remote_setpoint));
            ppid_pkg::PPID_SP_MULTI:  sp_v = ppid_sat(17'(multistage_setpoint));
            default:                  sp_v = 16'sd0;
        endcase
    end

    // same channel on both sides defeats regulation; nothing here prevents it
    always_comb begin
        case (fb_sel_q)
            ppid_pkg::PPID_FB_AN1: fb_v = ppid_sat(17'(analog_channel_one));
            ppid_pkg::PPID_FB_AN2: fb_v = ppid_sat(17'(analog_channel_two));
            ppid_pkg::PPID_FB_AN3: fb_v = ppid_sat(17'(analog_channel_three));
            ppid_pkg::PPID_FB_AN4: fb_v = ppid_sat(17'(analog_channel_four));
            ppid_pkg::PPID_FB_D12:
                fb_v = ppid_sat(17'(analog_channel_one) - 17'(analog_channel_two));
            ppid_pkg::PPID_FB_D34:
                fb_v = ppid_sat(17'(analog_channel_three) - 17'(analog_channel_four));
            ppid_pkg::PPID_FB_PL1: fb_v = ppid_sat(17'(pulse_input_one));
            ppid_pkg::PPID_FB_PL2: fb_v = ppid_sat(17'(pulse_input_two));
            ppid_pkg::PPID_FB_DPL:
                fb_v = ppid_sat(17'(pulse_input_one) - 17'(pulse_input_two));
            ppid_pkg::PPID_FB_REM: fb_v = ppid_sat(17'(remote_feedback));
            default:               fb_v = 16'sd0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // regulator arithmetic in 0.1 % of full scale; the command is then scaled by fmax

    logic signed [31:0] err, abs_err, p_t, i_t, d_t, acc_d, acc_lim, dfb, u_sum, u_sat;
    logic signed [31:0] kp_s, ti_s, td_s, ts_s, fmax_s;
    logic [31:0]        fcmd_w;

    assign kp_s   = $signed({16'h0000, kp_q});
    assign ti_s   = $signed({16'h0000, ti_q});
    assign td_s   = $signed({16'h0000, td_q});
    assign ts_s   = $signed({16'h0000, ts_q});
    assign fmax_s = $signed({16'h0000, fmax_q});

    always_comb begin
        // positive: high feedback gives negative error, lowering the command
        if (pol_q == ppid_pkg::PPID_POL_POS)
            err = 32'(sp_v) - 32'(fb_v);
        else
            err = 32'(fb_v) - 32'(sp_v);
        abs_err = (err < 0) ? -err : err;
        p_t     = (kp_s * err) / 32'sd10000;
        // accumulator holds error times period; divided by Ti it is the integral term
        acc_lim = ti_s * 32'sd1000;
        acc_d   = acc_q + err * ts_s;
        if (acc_d > acc_lim) acc_d = acc_lim;
        if (acc_d < -acc_lim) acc_d = -acc_lim;
        i_t     = acc_d / ti_s;
        // derivative acts on the feedback change, sign set by polarity
        dfb     = 32'(fb_v) - 32'(fb_prev_q);
        d_t     = (pol_q == ppid_pkg::PPID_POL_POS) ? -dfb : dfb;
        d_t     = (d_t * td_s) / ts_s;
        u_sum   = p_t + i_t + d_t;
        if (u_sum < 0) u_sat = 32'sd0;
        else if (u_sum > 32'sd1000) u_sat = 32'sd1000;
        else u_sat = u_sum;
        fcmd_w  = 32'((u_sat * fmax_s) / 32'sd1000);
    end

    ////////////////////////////////////////////////////////////////////////////
    // update state once per period

    assign pid_active   = (fsel_q == `PPID_FSEL_PID);
    assign freq_command = fcmd_q;

    // inactive regulator is cleared so it starts from rest when selected again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q     <= 32'sh0000_0000;
            fcmd_q    <= 16'h0000;
            fb_prev_q <= 16'sh0000;
            hold_q    <= 1'b0;
        end else if (!pid_active) begin
            acc_q     <= 32'sh0000_0000;
            fcmd_q    <= 16'h0000;
            fb_prev_q <= fb_v;
            hold_q    <= 1'b0;
        end else if (upd) begin
            fb_prev_q <= fb_v;
            hold_q    <= (abs_err <= $signed({16'h0000, dband_q}));
            if (abs_err > $signed({16'h0000, dband_q})) begin
                acc_q  <= acc_d;
                fcmd_q <= fcmd_w[15:0];
            end
        end
    end

endmodule : ppid_regulator

// file: testbench/ppid_regulator_sva.sv
// Purpose: port-level checks of the process regulator
// Assumes: single AHB-Lite slave, hready fed from hreadyout
// Notes:   fmax is mirrored from bus writes so the command bound follows it
`include "ppid_cfg.svh"
module ppid_regulator_sva #(
    parameter int unsigned UNIT_CYCLES = 10
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] freq_command,
    input wire logic        pid_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        taken;
    logic        wr_q;
    logic [7:0]  ofs_q;
    logic [15:0] fmax_q;
    assign taken = hsel && hready && htrans[1];
    ////////////////////////////////////////////////////////////////////////////
    // shadow of fmax, updated in the write data phase like the real register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            ofs_q  <= 8'h00;
            fmax_q <= `PPID_RST_FMAX;
        end else if (hready) begin
            wr_q  <= taken && hwrite;
            ofs_q <= haddr[7:0];
            if (wr_q && ofs_q == 8'h20) begin
                fmax_q <= hwdata[15:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // bus phases and the selector write
    sequence rd_taken;
        taken && !hwrite;
    endsequence
    sequence wr_taken;
        taken && hwrite;
    endsequence
    sequence fsel_write;
        wr_taken ##0 (haddr[7:0] == 8'h04) ##1 1'b1;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not OKAY");
    a_read_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    a_write_no_wait: assert property (wr_taken |=> hreadyout)
        else $error("write was stalled");
    a_unmapped_zero: assert property (rd_taken ##0 (haddr[7:0] >= 8'h2C) |=> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_active_on_pid: assert property (fsel_write ##0 (hwdata[3:0] == 4'h6) |=>
        pid_active)
        else $error("regulator not active after selector set to pid");
    a_idle_not_pid: assert property (fsel_write ##0 (hwdata[3:0] != 4'h6) |=>
        !pid_active)
        else $error("regulator active with another frequency source");
    a_inactive_clear: assert property (!pid_active |=> freq_command == 16'h0000)
        else $error("command not cleared while inactive");
    a_update_spacing: assert property ($changed(freq_command) && pid_active |=>
        (!pid_active || $stable(freq_command)) [*8])
        else $error("command changed twice within one period");
    a_cmd_bounded: assert property (freq_command <= fmax_q)
        else $error("command above maximum frequency");
endmodule : ppid_regulator_sva

// file: testbench/ppid_sensor_model.sv
// Purpose: behavioural process sensors and remote link feeding the regulator
// Assumes: levels in 0.1 % of full scale, 1000 being full scale
// Notes:   one clock of latency, like a sampled converter
module ppid_sensor_model (
    input  wire logic               hclk,
    input  wire logic signed [15:0] level [9],
    output logic signed [15:0]      chan  [9]
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // all channels sampled together so setpoint and feedback stay coherent
    always_ff @(posedge hclk) begin
        for (int i = 0; i < 9; i++) begin
            chan[i] <= level[i];
        end
    end
endmodule : ppid_sensor_model

// file: testbench/process_pid_regulator_bench.sv
// Purpose: self-checking bench of the process regulator
// Assumes: UNIT_CYCLES of 10, so a period step of 0.01 s is 10 clocks
// Notes:   random levels stay in 0..40 so the slow integral stays at zero
`include "ppid_cfg.svh"
module process_pid_regulator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UNIT = 10;
    localparam logic [31:0] RST_VAL [12] = '{32'h0, 32'h0, 32'h0, 32'h0000_000A,
        32'h0000_000A, 32'h0, 32'h0000_0032, 32'h0, 32'h0000_1388, 32'h0, 32'h0, 32'h0};
    logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, pid_active;
    logic [1:0]         htrans;
    logic [31:0]        haddr, hwdata, hrdata;
    logic [15:0]        freq_command;
    logic signed [15:0] level [9];
    logic signed [15:0] chan  [9];
    int                 mismatches = 0;
    int                 checks = 0;
    ppid_sensor_model ppid_sensor_model_inst (.hclk(hclk), .level(level), .chan(chan));
    ppid_regulator #(.UNIT_CYCLES(UNIT)) ppid_regulator_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .analog_channel_one(chan[0]), .analog_channel_two(chan[1]),
        .analog_channel_three(chan[2]), .analog_channel_four(chan[3]),
        .pulse_input_one(chan[4]), .pulse_input_two(chan[5]), .remote_setpoint(chan[6]),
        .remote_feedback(chan[7]), .multistage_setpoint(chan[8]),
        .freq_command(freq_command), .pid_active(pid_active));
    ////////////////////////////////////////////////////////////////////////////
    // clock, then report and comparison helpers
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic check_cmd(input int exp);
        check("freq_command", 32'(exp), {16'h0000, freq_command});
    endtask : check_cmd
    ////////////////////////////////////////////////////////////////////////////
    // bus master: ready judged at the settled negedge, acted on at the posedge
    task automatic wait_ready(output logic [31:0] rd);
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask : wait_ready
    task automatic bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, ofs};
        wait_ready(rd);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
    endtask : bus
    task automatic wreg(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, ofs, d, rd);
    endtask : wreg
    task automatic rcheck(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, ofs, 32'h0, rd);
        check($sformatf("register %h", ofs), exp, rd);
    endtask : rcheck
    // deactivate first so the integral starts from zero and the derivative history from the present feedback
    task automatic arm(input logic [31:0] src, input int kp, input int ti, input int td);
        wreg(8'h04, 32'h0);
        wreg(8'h0C, 32'(kp));
        wreg(8'h10, 32'(ti));
        wreg(8'h14, 32'(td));
        wreg(8'h00, src);
        wreg(8'h04, 32'h6);
    endtask : arm
    task automatic wait_change(output int cyc);
        logic [15:0] old;
        @(negedge hclk);
        old = freq_command;
        // the cycle spent since the negedge that saw the last change counts too
        cyc = 1;
        do begin
            @(negedge hclk);
            cyc++;
        end while (freq_command === old && cyc < 300);
        check("freq_command moved", 32'h1, 32'(freq_command !== old));
        @(posedge hclk);
    endtask : wait_change
    ////////////////////////////////////////////////////////////////////////////
    // reference model of source selection and the proportional path
    function automatic int sp_of(int code, int kpd);
        int map [9] = '{0, 0, 1, 2, 3, 4, 5, 6, 8};
        return code == 0 ? kpd : int'(level[map[code]]);
    endfunction : sp_of
    function automatic int fb_of(int code);
        case (code)
            4: return level[0] - level[1];
            5: return level[2] - level[3];
            8: return level[4] - level[5];
            9: return level[7];
            default: return level[code < 4 ? code : code - 2];
        endcase
    endfunction : fb_of
    function automatic int p_cmd(int e, int kp);
        int p;
        p = kp * e / 10000;
        p = p < 0 ? 0 : (p > 1000 ? 1000 : p);
        return p * `PPID_RST_FMAX / 1000;
    endfunction : p_cmd
    ////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        int          sp, fb, kp, kpd, cyc, e;
        logic [31:0] src;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        foreach (level[i]) level[i] = 16'h0000;
        void'($urandom(32'ha256_4374));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (RST_VAL[i]) begin
            if (i != 9) rcheck(8'(i * 4), RST_VAL[i]);
        end
        wreg(8'h00, 32'h0001_0203);
        wreg(8'h00, 32'h0000_0A09);
        rcheck(8'h00, 32'h0000_0203);
        wreg(8'h08, 32'hFFFF_FC18);
        wreg(8'h08, 32'h0000_03E9);
        rcheck(8'h08, 32'hFFFF_FC18);
        wreg(8'h28, 32'hFFFF_FFFF);
        rcheck(8'h28, 32'h0);
        wreg(8'h18, 32'h1);
        for (int k = 0; k < 10; k++) begin
            foreach (level[i]) level[i] <= 16'($urandom_range(40));
            kpd = $urandom_range(40);
            kp  = $urandom_range(10000);
            src = {15'h0, 1'(k % 2), 4'h0, 4'(k), 4'h0, 4'(k % 9)};
            wreg(8'h08, 32'(kpd));
            arm(src, kp, 1000, 0); // codes paired so no channel serves both sides
            repeat (3 * UNIT) @(posedge hclk);
            sp = sp_of(k % 9, kpd);
            fb = fb_of(k);
            e  = k % 2 ? fb - sp : sp - fb;
            check_cmd(p_cmd(e, kp));
        end
        // full error: the integral adds a tenth of fmax each period
        level[0] <= 16'h0000;
        wreg(8'h08, 32'h0000_03E8);
        arm(32'h0, 0, 10, 0);
        for (int k = 1; k <= 10; k++) begin
            wait_change(cyc);
            check_cmd(k * 500);
            if (k > 1) check("update gap", 32'(UNIT), 32'(cyc));
        end
        repeat (3 * UNIT) @(posedge hclk);
        check_cmd(5000);
        wreg(8'h1C, 32'h0000_03E8);
        wreg(8'h08, 32'hFFFF_FC18);
        repeat (3 * UNIT) @(posedge hclk);
        check_cmd(5000);
        rcheck(8'h24, 32'h0000_0003);
        wreg(8'h1C, 32'h0000_03E7);
        wait_change(cyc);
        check_cmd(4500);
        wreg(8'h04, 32'h5);
        rcheck(8'h28, 32'h0);
        // a feedback step with negative polarity gives one derivative kick
        wreg(8'h1C, 32'h0);
        wreg(8'h08, 32'h0);
        arm(32'h0001_0000, 0, 1000, 10);
        repeat (3 * UNIT) @(posedge hclk);
        level[0] <= 16'h0064;
        wait_change(cyc);
        check_cmd(5000);
        wait_change(cyc);
        check_cmd(0);
        // a double step asks for twice the maximum; the sum must clip at the top
        level[0] <= 16'h012C;
        wait_change(cyc);
        check_cmd(5000);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        conclude();
    end
endmodule : process_pid_regulator_bench

bind ppid_regulator ppid_regulator_sva #(.UNIT_CYCLES(UNIT_CYCLES)) ppid_regulator_sva_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .freq_command(freq_command), .pid_active(pid_active));
